/* File: inc/cbi_pkg.sv */
// Shared constants and types of the cache bus interface unit
package cbi_pkg;
	localparam int KB_BYTES = 1024;
	localparam int WORD_BYTES = 4;
	localparam int WORD_LSB = 2;
	localparam int LINE_LSB = 4;
	localparam int LINE_BYTES = 16;
	localparam int QUAD_N = 4;
	localparam int DC_BYTES = 2048;
	localparam int DC_LINES = DC_BYTES / WORD_BYTES;
	localparam int IC_KB_DEF = 4;
	localparam int WB_DEPTH_DEF = 4;
	localparam logic [3:0] BE_ALL = 4'hf;
	localparam logic [1:0] WORD0 = 2'h0;
	localparam logic [1:0] BYTE0 = 2'h0;
	localparam logic [1:0] WORD_LAST = 2'h3;
	// Strap sampling waits until the pin synchroniser holds the real level
	localparam logic [2:0] CFG_SETTLE = 3'h5;

	typedef enum logic [1:0] {
		KIND_FETCH = 2'h0,
		KIND_LOAD = 2'h1,
		KIND_STORE = 2'h2
	} cbi_kind_t;

	typedef struct packed {
		cbi_kind_t kind;
		logic unc;
		logic [31:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} cbi_req_t;

	typedef struct packed {
		logic [29:0] waddr;
		logic [3:0] be;
		logic [31:0] data;
	} cbi_wb_t;

	typedef struct packed {
		logic ale;
		logic rd;
		logic wr;
		logic data_en;
		logic burst;
		logic [1:0] addr_lo;
	} cbi_bus_t;

	typedef enum logic [4:0] {
		C_IDLE = 5'h01,
		C_LOOK = 5'h02,
		C_WAIT = 5'h04,
		C_FILL = 5'h08,
		C_DONE = 5'h10
	} cbi_cst_t;

	typedef enum logic [4:0] {
		B_IDLE = 5'h01,
		B_ADDR = 5'h02,
		B_WRITE = 5'h04,
		B_READ = 5'h08,
		B_DMA = 5'h10
	} cbi_bst_t;
endpackage

/* File: hw/cbi_sync.sv */
// Three-stage pin synchroniser with optional agreement filter
module cbi_sync #(
	parameter int W = 1,
	parameter bit FILTER = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Pin side and clock side
	input wire logic [W-1:0] in_a,
	output logic [W-1:0] out_s
);
	logic [W-1:0] s1_q, s2_q, s3_q, hold_q, hold_d;

	// Only the second and third stages are compared; the first feeds nothing else
	always_comb begin
		if (FILTER) begin
			out_s = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & hold_q);
		end else begin
			out_s = s3_q;
		end
		hold_d = out_s;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			hold_q <= '0;
		end else begin
			s1_q <= in_a;
			s2_q <= s1_q;
			s3_q <= s2_q;
			hold_q <= hold_d;
		end
	end
endmodule

/* File: hw/cbi_ram.sv */
// Single-port memory with registered read data
module cbi_ram #(
	parameter int W = 32,
	parameter int DEPTH = 512
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Access port
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] addr,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [DEPTH];

	if (DEPTH < 2) begin : g_bad_depth
		$error("cbi_ram DEPTH must be at least 2");
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= '0;
		end else begin
			rdata <= mem[addr];
		end
	end
endmodule

/* File: hw/cbi_bus_unit.sv */
// Bus interface unit: caches, write buffer, read buffer, bus arbiter
module cbi_bus_unit #(
	parameter int IC_KB = cbi_pkg::IC_KB_DEF,
	parameter int WB_DEPTH = cbi_pkg::WB_DEPTH_DEF
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Processor request port
	input wire logic cpu_req,
	input wire cbi_pkg::cbi_req_t cpu_cmd,
	output logic cpu_ack,
	output logic [31:0] cpu_rdata,
	// Multiplexed bus
	input wire logic [31:0] ad_in,
	output logic [31:0] ad_out,
	output logic ad_oe,
	output cbi_pkg::cbi_bus_t bus_ctl,
	input wire logic ack,
	input wire logic read_buffer_capture_enable,
	// Arbitration and strap
	input wire logic dma_req,
	output logic dma_grant,
	input wire logic dquad_strap
);
	localparam int IC_BYTES = IC_KB * cbi_pkg::KB_BYTES;
	localparam int IC_LINES = IC_BYTES / cbi_pkg::LINE_BYTES;
	localparam int IC_IW = $clog2(IC_LINES);
	localparam int IC_TW = 32 - $clog2(IC_BYTES);
	localparam int DC_IW = $clog2(cbi_pkg::DC_LINES);
	localparam int DC_TW = 32 - $clog2(cbi_pkg::DC_BYTES);
	localparam int WB_AW = $clog2(WB_DEPTH);

	if (IC_KB != 4 && IC_KB != 8) begin : g_bad_ic
		$error("IC_KB must be 4 or 8");
	end
	if (WB_DEPTH < 2 || (1 << WB_AW) != WB_DEPTH) begin : g_bad_wb
		$error("WB_DEPTH must be a power of two of at least 2");
	end

	function automatic logic [1:0] word_of(input logic [31:0] a);
		return a[cbi_pkg::LINE_LSB-1:cbi_pkg::WORD_LSB];
	endfunction
	function automatic logic [DC_IW-1:0] dc_idx(input logic [31:0] a);
		return a[DC_IW+cbi_pkg::WORD_LSB-1:cbi_pkg::WORD_LSB];
	endfunction
	function automatic logic [DC_TW-1:0] dc_tag(input logic [31:0] a);
		return a[31:32-DC_TW];
	endfunction
	function automatic logic [IC_IW-1:0] ic_idx(input logic [31:0] a);
		return a[IC_IW+cbi_pkg::LINE_LSB-1:cbi_pkg::LINE_LSB];
	endfunction
	function automatic logic [IC_TW-1:0] ic_tag(input logic [31:0] a);
		return a[31:32-IC_TW];
	endfunction

	logic [3:0] ctl_s;
	logic dma_s, strap_s, read_buffer_capture_enable_s, ack_s;
	logic [31:0] ad_s;

	cbi_sync #(.W(4), .FILTER(1'b1)) u_ctl_sync (
		.clk(clk),
		.nrst(nrst),
		.in_a({dma_req, dquad_strap, read_buffer_capture_enable, ack}),
		.out_s(ctl_s)
	);
	assign {dma_s, strap_s, read_buffer_capture_enable_s, ack_s} = ctl_s;

	// Data stays aligned with the filtered strobes by the same three stages
	cbi_sync #(.W(32), .FILTER(1'b0)) u_ad_sync (
		.clk(clk),
		.nrst(nrst),
		.in_a(ad_in),
		.out_s(ad_s)
	);

	// Strap capture
	logic [2:0] cfg_cnt_q, cfg_cnt_d;
	logic dquad_q, dquad_d, cfg_done;
	assign cfg_done = (cfg_cnt_q == cbi_pkg::CFG_SETTLE);

	always_comb begin
		cfg_cnt_d = cfg_cnt_q;
		dquad_d = dquad_q;
		if (!cfg_done) begin
			cfg_cnt_d = cfg_cnt_q + 3'h1;
			dquad_d = strap_s;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_cnt_q <= '0;
			dquad_q <= 1'b0;
		end else begin
			cfg_cnt_q <= cfg_cnt_d;
			dquad_q <= dquad_d;
		end
	end

	// Write buffer
	cbi_pkg::cbi_wb_t wb_q [WB_DEPTH], wb_d [WB_DEPTH], wb_head;
	logic [WB_AW-1:0] wb_wp_q, wb_wp_d, wb_rp_q, wb_rp_d;
	logic [WB_AW:0] wb_cnt_q, wb_cnt_d;
	logic wb_push, wb_pop, wb_full;
	assign wb_full = (wb_cnt_q == (WB_AW+1)'(WB_DEPTH));
	assign wb_head = wb_q[wb_rp_q];

	always_comb begin
		wb_d = wb_q;
		wb_wp_d = wb_wp_q;
		wb_rp_d = wb_rp_q;
		if (wb_push) begin
			wb_d[wb_wp_q] = {cpu_cmd.addr[31:cbi_pkg::WORD_LSB], cpu_cmd.be, cpu_cmd.wdata};
			wb_wp_d = wb_wp_q + WB_AW'(1);
		end
		if (wb_pop) begin
			wb_rp_d = wb_rp_q + WB_AW'(1);
		end
		wb_cnt_d = wb_cnt_q + (WB_AW+1)'(wb_push) - (WB_AW+1)'(wb_pop);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wb_q <= '{default: '0};
			wb_wp_q <= '0;
			wb_rp_q <= '0;
			wb_cnt_q <= '0;
		end else begin
			wb_q <= wb_d;
			wb_wp_q <= wb_wp_d;
			wb_rp_q <= wb_rp_d;
			wb_cnt_q <= wb_cnt_d;
		end
	end

	// Caches
	logic dc_we, ict_we, icd_we;
	logic [DC_IW-1:0] dc_a;
	logic [IC_IW-1:0] ict_a;
	logic [IC_IW+1:0] icd_a;
	logic [DC_TW+31:0] dc_wd, dc_rd;
	logic [IC_TW-1:0] ict_wd, ict_rd;
	logic [31:0] icd_wd, icd_rd;
	logic [cbi_pkg::DC_LINES-1:0] dcv_q, dcv_d;
	logic [IC_LINES-1:0] icv_q, icv_d;

	cbi_ram #(.W(DC_TW+32), .DEPTH(cbi_pkg::DC_LINES)) u_dcache (
		.clk(clk), .nrst(nrst), .we(dc_we), .addr(dc_a), .wdata(dc_wd), .rdata(dc_rd)
	);
	cbi_ram #(.W(IC_TW), .DEPTH(IC_LINES)) u_itag (
		.clk(clk), .nrst(nrst), .we(ict_we), .addr(ict_a), .wdata(ict_wd), .rdata(ict_rd)
	);
	cbi_ram #(.W(32), .DEPTH(IC_LINES*cbi_pkg::QUAD_N)) u_idata (
		.clk(clk), .nrst(nrst), .we(icd_we), .addr(icd_a), .wdata(icd_wd), .rdata(icd_rd)
	);

	// Processor side
	cbi_pkg::cbi_cst_t cs_q, cs_d;
	cbi_pkg::cbi_req_t req_q, req_d;
	logic quad_q, quad_d, rd_done, is_fetch, ic_hit, dc_hit;
	logic [1:0] fill_q, fill_d;
	logic [31:0] rdata_q, rdata_d, fill_a;
	logic [31:0] rb_q [cbi_pkg::QUAD_N], rb_d [cbi_pkg::QUAD_N];

	assign is_fetch = (req_q.kind == cbi_pkg::KIND_FETCH);
	// Tags cover every physical address bit, so no flush on context change
	assign ic_hit = icv_q[ic_idx(req_q.addr)] && (ict_rd == ic_tag(req_q.addr));
	assign dc_hit = dcv_q[dc_idx(req_q.addr)] && (dc_rd[DC_TW+31:32] == dc_tag(req_q.addr));
	assign fill_a = quad_q ? {req_q.addr[31:cbi_pkg::LINE_LSB], fill_q, cbi_pkg::BYTE0} : req_q.addr;
	assign cpu_rdata = rdata_q;

	always_comb begin
		cs_d = cs_q;
		req_d = req_q;
		quad_d = quad_q;
		fill_d = fill_q;
		rdata_d = rdata_q;
		dcv_d = dcv_q;
		icv_d = icv_q;
		wb_push = 1'b0;
		cpu_ack = 1'b0;
		dc_we = 1'b0;
		dc_a = dc_idx(cpu_cmd.addr);
		dc_wd = {dc_tag(cpu_cmd.addr), cpu_cmd.wdata};
		ict_we = 1'b0;
		ict_a = ic_idx(cpu_cmd.addr);
		ict_wd = ic_tag(req_q.addr);
		icd_we = 1'b0;
		icd_a = {ic_idx(cpu_cmd.addr), word_of(cpu_cmd.addr)};
		icd_wd = rb_q[fill_q];
		case (cs_q)
			cbi_pkg::C_IDLE: begin
				if (cpu_req && cfg_done) begin
					if (cpu_cmd.kind == cbi_pkg::KIND_STORE) begin
						if (!wb_full) begin
							wb_push = 1'b1;
							cpu_ack = 1'b1;
							// Partial stores drop the line rather than merge bytes
							if (!cpu_cmd.unc) begin
								dc_we = (cpu_cmd.be == cbi_pkg::BE_ALL);
								dcv_d[dc_idx(cpu_cmd.addr)] = (cpu_cmd.be == cbi_pkg::BE_ALL);
							end
						end
					end else begin
						req_d = cpu_cmd;
						cs_d = cbi_pkg::C_LOOK;
					end
				end
			end
			cbi_pkg::C_LOOK: begin
				if (!req_q.unc && (is_fetch ? ic_hit : dc_hit)) begin
					rdata_d = is_fetch ? icd_rd : dc_rd[31:0];
					cs_d = cbi_pkg::C_DONE;
				end else begin
					quad_d = !req_q.unc && (is_fetch || dquad_q);
					cs_d = cbi_pkg::C_WAIT;
				end
			end
			cbi_pkg::C_WAIT: begin
				if (rd_done) begin
					fill_d = cbi_pkg::WORD0;
					cs_d = cbi_pkg::C_FILL;
				end
			end
			cbi_pkg::C_FILL: begin
				if (!req_q.unc && is_fetch) begin
					icd_we = 1'b1;
					icd_a = {ic_idx(fill_a), word_of(fill_a)};
					ict_we = 1'b1;
					ict_a = ic_idx(fill_a);
					icv_d[ic_idx(fill_a)] = 1'b1;
				end else if (!req_q.unc) begin
					dc_we = 1'b1;
					dc_a = dc_idx(fill_a);
					dc_wd = {dc_tag(fill_a), rb_q[fill_q]};
					dcv_d[dc_idx(fill_a)] = 1'b1;
				end
				if (!quad_q || fill_q == word_of(req_q.addr)) begin
					rdata_d = rb_q[fill_q];
				end
				if (!quad_q || fill_q == cbi_pkg::WORD_LAST) begin
					cs_d = cbi_pkg::C_DONE;
				end else begin
					fill_d = fill_q + 2'h1;
				end
			end
			cbi_pkg::C_DONE: begin
				cpu_ack = 1'b1;
				cs_d = cbi_pkg::C_IDLE;
			end
			default: cs_d = cbi_pkg::C_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cs_q <= cbi_pkg::C_IDLE;
			req_q <= '0;
			quad_q <= 1'b0;
			fill_q <= '0;
			rdata_q <= '0;
			dcv_q <= '0;
			icv_q <= '0;
		end else begin
			cs_q <= cs_d;
			req_q <= req_d;
			quad_q <= quad_d;
			fill_q <= fill_d;
			rdata_q <= rdata_d;
			dcv_q <= dcv_d;
			icv_q <= icv_d;
		end
	end

	// Bus side
	cbi_pkg::cbi_bst_t bs_q, bs_d;
	logic wr_q, wr_d, seen_q, seen_d;
	logic [1:0] lo_q, lo_d;
	logic [2:0] rb_cnt_q, rb_cnt_d, rb_need;
	logic [31:0] ad_out_q, ad_out_d;
	assign rb_need = quad_q ? 3'(cbi_pkg::QUAD_N) : 3'h1;

	always_comb begin
		bs_d = bs_q;
		wr_d = wr_q;
		seen_d = seen_q;
		lo_d = lo_q;
		rb_d = rb_q;
		rb_cnt_d = rb_cnt_q;
		ad_out_d = ad_out_q;
		wb_pop = 1'b0;
		rd_done = 1'b0;
		case (bs_q)
			cbi_pkg::B_IDLE: begin
				if (dma_s) begin
					bs_d = cbi_pkg::B_DMA;
				end else if (wb_cnt_q != '0) begin
					wr_d = 1'b1;
					ad_out_d = {wb_head.waddr[29:cbi_pkg::LINE_LSB-cbi_pkg::WORD_LSB], wb_head.be};
					lo_d = wb_head.waddr[1:0];
					bs_d = cbi_pkg::B_ADDR;
				end else if (cs_q == cbi_pkg::C_WAIT) begin
					// Reads go out only once every queued store has retired
					wr_d = 1'b0;
					ad_out_d = {req_q.addr[31:cbi_pkg::LINE_LSB], cbi_pkg::BE_ALL};
					lo_d = quad_q ? cbi_pkg::WORD0 : word_of(req_q.addr);
					rb_cnt_d = '0;
					seen_d = 1'b0;
					bs_d = cbi_pkg::B_ADDR;
				end
			end
			cbi_pkg::B_ADDR: begin
				if (wr_q) begin
					ad_out_d = wb_head.data;
				end
				bs_d = wr_q ? cbi_pkg::B_WRITE : cbi_pkg::B_READ;
			end
			cbi_pkg::B_WRITE: begin
				if (ack_s) begin
					wb_pop = 1'b1;
					bs_d = cbi_pkg::B_IDLE;
				end
			end
			cbi_pkg::B_READ: begin
				if (read_buffer_capture_enable_s && rb_cnt_q != rb_need) begin
					rb_d[rb_cnt_q[1:0]] = ad_s;
					rb_cnt_d = rb_cnt_q + 3'h1;
					if (quad_q) begin
						lo_d = lo_q + 2'h1;
					end
				end
				seen_d = seen_q | ack_s;
				if (rb_cnt_d == rb_need && seen_d) begin
					rd_done = 1'b1;
					bs_d = cbi_pkg::B_IDLE;
				end
			end
			cbi_pkg::B_DMA: begin
				if (!dma_s) begin
					bs_d = cbi_pkg::B_IDLE;
				end
			end
			default: bs_d = cbi_pkg::B_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bs_q <= cbi_pkg::B_IDLE;
			wr_q <= 1'b0;
			seen_q <= 1'b0;
			lo_q <= '0;
			rb_q <= '{default: '0};
			rb_cnt_q <= '0;
			ad_out_q <= '0;
		end else begin
			bs_q <= bs_d;
			wr_q <= wr_d;
			seen_q <= seen_d;
			lo_q <= lo_d;
			rb_q <= rb_d;
			rb_cnt_q <= rb_cnt_d;
			ad_out_q <= ad_out_d;
		end
	end

	assign ad_out = ad_out_q;
	assign ad_oe = (bs_q == cbi_pkg::B_ADDR) || (bs_q == cbi_pkg::B_WRITE);
	assign dma_grant = (bs_q == cbi_pkg::B_DMA);
	assign bus_ctl = {bs_q == cbi_pkg::B_ADDR, bs_q == cbi_pkg::B_READ, bs_q == cbi_pkg::B_WRITE,
		bs_q == cbi_pkg::B_READ,
		quad_q && !wr_q && (bs_q == cbi_pkg::B_ADDR || bs_q == cbi_pkg::B_READ), lo_q};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	property p_addr_phase;
		bus_ctl.ale |-> ad_oe ##1 !bus_ctl.ale;
	endproperty
	a_addr_phase: assert property (p_addr_phase) else $error("address strobe not single");
	property p_wr_data;
		(bus_ctl.ale && wr_q) |=> (bus_ctl.wr && ad_oe && ad_out == $past(wb_head.data));
	endproperty
	a_wr_data: assert property (p_wr_data) else $error("write data phase wrong");
	property p_dma_quiet;
		dma_grant |-> !ad_oe && !bus_ctl.ale && !bus_ctl.rd && !bus_ctl.wr;
	endproperty
	a_dma_quiet: assert property (p_dma_quiet) else $error("bus driven while granted");
	property p_dma_take;
		(bs_q == cbi_pkg::B_IDLE && dma_s) |=> dma_grant;
	endproperty
	a_dma_take: assert property (p_dma_take) else $error("grant not given");
	property p_wb_fifo;
		(bus_ctl.wr && ack_s) |=> (wb_rp_q == $past(wb_rp_q) + WB_AW'(1)) && !bus_ctl.wr;
	endproperty
	a_wb_fifo: assert property (p_wb_fifo) else $error("write not retired in order");
	property p_wb_through;
		(cpu_ack && cs_q == cbi_pkg::C_IDLE) |=> (wb_cnt_q != '0);
	endproperty
	a_wb_through: assert property (p_wb_through) else $error("store not queued");
	property p_wb_stall;
		(cs_q == cbi_pkg::C_IDLE && cpu_req && cpu_cmd.kind == cbi_pkg::KIND_STORE && wb_full)
			|-> !cpu_ack;
	endproperty
	a_wb_stall: assert property (p_wb_stall) else $error("store taken while full");
	property p_lo_zero;
		(bus_ctl.ale && bus_ctl.burst) |-> bus_ctl.addr_lo == cbi_pkg::WORD0;
	endproperty
	a_lo_zero: assert property (p_lo_zero) else $error("quad read not from word zero");
	property p_lo_step;
		(bus_ctl.rd && quad_q && read_buffer_capture_enable_s && rb_cnt_q != rb_need)
			|=> bus_ctl.addr_lo == $past(bus_ctl.addr_lo) + 2'h1;
	endproperty
	a_lo_step: assert property (p_lo_step) else $error("word counter did not step");
	property p_fetch_quad;
		(bus_ctl.ale && !wr_q && is_fetch && !req_q.unc) |-> bus_ctl.burst;
	endproperty
	a_fetch_quad: assert property (p_fetch_quad) else $error("fetch miss not quad");
	property p_capture;
		(bus_ctl.rd && read_buffer_capture_enable_s && rb_cnt_q != rb_need) |=> rb_cnt_q == $past(rb_cnt_q) + 3'h1;
	endproperty
	a_capture: assert property (p_capture) else $error("capture enable lost a word");
	property p_fill;
		(rd_done && quad_q) |=> (cs_q == cbi_pkg::C_FILL)[*4] ##1 cs_q == cbi_pkg::C_DONE;
	endproperty
	a_fill: assert property (p_fill) else $error("line fill not a four-cycle burst");
	property p_strap;
		cfg_done |=> cfg_done && $stable(dquad_q);
	endproperty
	a_strap: assert property (p_strap) else $error("refill option changed");

	c_quad_fill: cover property (rd_done && quad_q);
	c_dma: cover property (dma_grant);
	c_wb_full: cover property (wb_full && cpu_req);
	c_hit: cover property (cs_q == cbi_pkg::C_LOOK ##1 cs_q == cbi_pkg::C_DONE);
endmodule

/* File: verification/cbi_mem_model.sv */
// Memory and controller model on the far side of the multiplexed bus
module cbi_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Bus driven by the unit
	input wire logic [31:0] ad_out,
	input wire cbi_pkg::cbi_bus_t bus_ctl,
	// Pace: a gap before each write answer; read words streamed, or a gap before read words 0 and 2
	input wire logic fast,
	input wire logic [3:0] gap,
	// Answers to the unit
	output logic [31:0] ad_in,
	output logic ack,
	output logic read_buffer_capture_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [logic [29:0]];
	logic [29:0] la;
	logic [3:0] lbe;
	logic [3:0] wcnt;
	logic [1:0] idx;
	logic quad;
	logic done;
	logic ack_h, rce_h, ack_now, rce_now;
	logic [31:0] ad_nx;

	function automatic logic [31:0] peek(input logic [29:0] a);
		return mem.exists(a) ? mem[a] : {a[15:0] ^ 16'h3c5a, a[15:0]};
	endfunction

	// The unit's pin filter drops one-cycle pulses, so every strobe stands two cycles at least;
	// slow words therefore come in pairs, each pair after a pause of two cycles at least
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack <= 1'b0;
			read_buffer_capture_enable <= 1'b0;
			ack_h <= 1'b0;
			rce_h <= 1'b0;
			ad_in <= 32'h0000_0000;
			done <= 1'b1;
		end else begin
			ack_now = 1'b0;
			rce_now = 1'b0;
			// Undriven bus never keeps its last value
			ad_nx = ~ad_in;
			if (bus_ctl.ale) begin
				la <= {ad_out[31:4], bus_ctl.addr_lo};
				lbe <= ad_out[3:0];
				quad <= bus_ctl.burst;
				wcnt <= 4'h0;
				idx <= 2'h0;
				done <= 1'b0;
			end else if (bus_ctl.wr && !done) begin
				if (wcnt == gap) begin
					for (int i = 0; i < 4; i++) begin
						if (lbe[i]) mem[la] = {peek(la)} & ~(32'h0000_00ff << (8 * i)) |
							(ad_out & (32'h0000_00ff << (8 * i)));
					end
					ack_now = 1'b1;
					done <= 1'b1;
				end else begin
					wcnt <= wcnt + 4'h1;
				end
			end else if (bus_ctl.rd && !done) begin
				if (!fast && !idx[0] && wcnt != (gap | 4'h2)) begin
					wcnt <= wcnt + 4'h1;
				end else begin
					ad_nx = peek(quad ? {la[29:2], idx} : la);
					rce_now = 1'b1;
					wcnt <= 4'h0;
					idx <= idx + 2'h1;
					if (!quad || idx == 2'h3) begin
						ack_now = 1'b1;
						done <= 1'b1;
					end
				end
			end
			ad_in <= ad_nx;
			ack <= ack_now | ack_h;
			ack_h <= ack_now;
			read_buffer_capture_enable <= rce_now | rce_h;
			rce_h <= rce_now & !quad;
		end
	end
endmodule

/* File: verification/cpu_cache_bus_interface_tb.sv */
// Self-checking bench of the bus interface unit against a memory model
module cpu_cache_bus_interface_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, nrst, cpu_req, cpu_ack, ad_oe, ack, read_buffer_capture_enable;
	logic dma_req, dma_grant, dquad_strap, fast, rd_q;
	logic [31:0] cpu_rdata, ad_in, ad_out, a;
	logic [3:0] gap;
	cbi_pkg::cbi_req_t cpu_cmd;
	cbi_pkg::cbi_bus_t bus_ctl;
	cbi_pkg::cbi_kind_t k;
	int err_count, tests_run, seed, lat, nrd, nburst, i;
	logic [31:0] r;
	logic [31:0] shadow [logic [29:0]];

	cbi_bus_unit #(.IC_KB(4), .WB_DEPTH(4)) DUT (.clk(clk), .nrst(nrst), .cpu_req(cpu_req),
		.cpu_cmd(cpu_cmd), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata), .ad_in(ad_in),
		.ad_out(ad_out), .ad_oe(ad_oe), .bus_ctl(bus_ctl), .ack(ack),
		.read_buffer_capture_enable(read_buffer_capture_enable), .dma_req(dma_req),
		.dma_grant(dma_grant), .dquad_strap(dquad_strap));
	cbi_mem_model mem_model (.clk(clk), .nrst(nrst), .ad_out(ad_out), .bus_ctl(bus_ctl),
		.fast(fast), .gap(gap), .ad_in(ad_in), .ack(ack),
		.read_buffer_capture_enable(read_buffer_capture_enable));

	always #50 clk = ~clk;

	function automatic logic [31:0] word(input logic [29:0] w);
		return shadow.exists(w) ? shadow[w] : {w[15:0] ^ 16'h3c5a, w[15:0]};
	endfunction

	function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] be);
		for (int j = 0; j < 4; j++) begin
			if (be[j]) o[8*j +: 8] = d[8*j +: 8];
		end
		return o;
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One processor access; erd and ebu are expected bus reads and bursts, negative to skip
	task automatic acc(input cbi_pkg::cbi_kind_t kd, input logic u, input logic [31:0] ad,
		input logic [3:0] be, input logic [31:0] d, input int erd, input int ebu);
		int n, r0, b0;
		r0 = nrd;
		b0 = nburst;
		n = 0;
		@(posedge clk);
		cpu_req <= 1'b1;
		cpu_cmd <= '{kind: kd, unc: u, addr: ad, be: be, wdata: d};
		do begin
			@(negedge clk);
			n++;
		end while (cpu_ack !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			chk("cpu_ack", 32'h0000_0001, 32'h0000_0000);
			test_done();
		end
		lat = n - 1;
		if (kd == cbi_pkg::KIND_STORE) shadow[ad[31:2]] = mrg(word(ad[31:2]), d, be);
		else chk("cpu_rdata", word(ad[31:2]), cpu_rdata);
		@(posedge clk);
		cpu_req <= 1'b0;
		if (erd >= 0) chk("bus_reads", erd, nrd - r0);
		if (ebu >= 0) chk("bursts", ebu, nburst - b0);
	endtask

	always @(negedge clk) begin
		rd_q <= bus_ctl.rd;
		if (bus_ctl.rd && !rd_q) nrd++;
		if (bus_ctl.data_en) chk("ad_oe_data", 32'h0000_0000, ad_oe);
		if (bus_ctl.ale) chk("ad_oe_addr", 32'h0000_0001, ad_oe);
		if (bus_ctl.ale && bus_ctl.burst) begin
			nburst++;
			chk("addr_lo", 32'h0000_0000, bus_ctl.addr_lo);
		end
	end

	initial begin
		seed = 5872;
		clk = 1'b0;
		nrst = 1'b0;
		cpu_req = 1'b0;
		cpu_cmd = '0;
		dma_req = 1'b0;
		dquad_strap = 1'b0;
		fast = 1'b0;
		gap = 4'h2;
		rd_q = 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		acc(cbi_pkg::KIND_FETCH, 1'b0, 32'h0000_2100, 4'hf, 32'h0000_0000, 1, 1);
		acc(cbi_pkg::KIND_FETCH, 1'b0, 32'h0000_210c, 4'hf, 32'h0000_0000, 0, 0);
		chk("hit_latency", 32'h0000_0002, lat);
		acc(cbi_pkg::KIND_FETCH, 1'b0, 32'h0000_3100, 4'hf, 32'h0000_0000, 1, 1);
		acc(cbi_pkg::KIND_FETCH, 1'b0, 32'h0000_2104, 4'hf, 32'h0000_0000, 1, 1);
		fast <= 1'b1;
		acc(cbi_pkg::KIND_FETCH, 1'b0, 32'h0000_2200, 4'hf, 32'h0000_0000, 1, 1);
		fast <= 1'b0;
		acc(cbi_pkg::KIND_LOAD, 1'b0, 32'h0000_0040, 4'hf, 32'h0000_0000, 1, 0);
		acc(cbi_pkg::KIND_LOAD, 1'b0, 32'h0000_0040, 4'hf, 32'h0000_0000, 0, 0);
		acc(cbi_pkg::KIND_LOAD, 1'b0, 32'h0000_0840, 4'hf, 32'h0000_0000, 1, 0);
		acc(cbi_pkg::KIND_STORE, 1'b0, 32'h0000_0044, 4'hf, 32'h1234_5678, -1, -1);
		acc(cbi_pkg::KIND_LOAD, 1'b0, 32'h0000_0044, 4'hf, 32'h0000_0000, 0, 0);
		acc(cbi_pkg::KIND_LOAD, 1'b1, 32'h0000_0044, 4'hf, 32'h0000_0000, 1, 0);
		// Slow memory so the fifth store finds the buffer full
		gap <= 4'hf;
		for (i = 0; i < 5; i++) begin
			a = 32'h0000_0300 | (i[0] << 2);
			acc(cbi_pkg::KIND_STORE, 1'b0, a, 4'hf, $random(seed), -1, -1);
			chk("store_stall", i == 4, lat != 0);
		end
		gap <= 4'h2;
		acc(cbi_pkg::KIND_LOAD, 1'b1, 32'h0000_0300, 4'hf, 32'h0000_0000, 1, 0);
		acc(cbi_pkg::KIND_LOAD, 1'b1, 32'h0000_0304, 4'hf, 32'h0000_0000, 1, 0);
		@(posedge clk);
		dma_req <= 1'b1;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (dma_grant !== 1'b1 && i < 20);
		if (i >= 20) begin
			err_count++;
			test_done();
		end
		repeat (3) @(negedge clk);
		chk("dma_grant", 32'h0000_0001, dma_grant);
		// Strobes and drive are off; the low word address still names the last single read
		chk("dma_bus_free", 32'h0000_0001, {ad_oe, bus_ctl});
		@(posedge clk);
		dma_req <= 1'b0;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (dma_grant !== 1'b0 && i < 20);
		chk("dma_release", 32'h0000_0000, dma_grant);
		if (i >= 20) test_done();
		for (int m = 0; m < 80; m++) begin
			r = $random(seed);
			fast <= r[20];
			gap <= {1'b0, r[19:17]};
			k = cbi_pkg::cbi_kind_t'(r[1:0] == 2'h3 ? 2'h1 : r[1:0]);
			a = {19'h0_0000, k == cbi_pkg::KIND_FETCH, r[11:2], 2'b00};
			acc(k, k == cbi_pkg::KIND_LOAD && r[16], a,
				(k == cbi_pkg::KIND_STORE && r[15:12] != 4'h0) ? r[15:12] : 4'hf,
				$random(seed), -1, -1);
		end
		// Drain the buffer, then reset with four-word data refill strapped
		acc(cbi_pkg::KIND_LOAD, 1'b1, 32'h0000_0000, 4'hf, 32'h0000_0000, -1, -1);
		@(posedge clk);
		nrst <= 1'b0;
		dquad_strap <= 1'b1;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		dquad_strap <= 1'b0;
		acc(cbi_pkg::KIND_LOAD, 1'b0, 32'h0000_0480, 4'hf, 32'h0000_0000, 1, 1);
		acc(cbi_pkg::KIND_LOAD, 1'b0, 32'h0000_048c, 4'hf, 32'h0000_0000, 0, 0);
		acc(cbi_pkg::KIND_LOAD, 1'b1, 32'h0000_0484, 4'hf, 32'h0000_0000, 1, 0);
		test_done();
	end
endmodule
